// [verilog/cssu_map.svh]
// cssu_map.svh: offsets, field positions, reset values and timing figures of the
// clock source select and start-up block.
// assumes inclusion by bare name from the package and the design modules.
`ifndef CSSU_MAP_SVH
`define CSSU_MAP_SVH

// apb register byte offsets
`define CSSU_OFS_TRIM       8'h00
`define CSSU_OFS_PRESCALE   8'h04
`define CSSU_OFS_TIMER_CTRL 8'h08
`define CSSU_OFS_STATUS     8'h0c

// clock source select fuse codes
`define CSSU_SRC_EXTERNAL 4'h0
`define CSSU_SRC_RC       4'h2
`define CSSU_SRC_LOWFREQ  4'h3

// start-up time fuse codes
`define CSSU_SUT_NONE     2'h0
`define CSSU_SUT_SHORT    2'h1
`define CSSU_SUT_LONG     2'h2
`define CSSU_SUT_RESERVED 2'h3

// shipped fuse word: clock out off, div8 on, sut 10, rc source
`define CSSU_FUSE_SHIPPED 8'h62

// prescaler select reset values and largest legal code
`define CSSU_PRESC_DIV1  4'h0
`define CSSU_PRESC_DIV8  4'h3
`define CSSU_PRESC_MAX   4'h8

// timer control fields
`define CSSU_TCTRL_OSC_EN_BIT 0
`define CSSU_TCTRL_EXTERNAL_CLOCK_PIN_BIT 1

// status fields
`define CSSU_STAT_SRC_LSB      0
`define CSSU_STAT_SUT_LSB      4
`define CSSU_STAT_DIV8_BIT     6
`define CSSU_STAT_CLKOUT_BIT   7
`define CSSU_STAT_RUNNING_BIT  8
`define CSSU_STAT_TIMER_BIT    9
`define CSSU_STAT_SUT_BAD_BIT  10
`define CSSU_STAT_SRC_BAD_BIT  11

// oscillator models: 16-bit phase step per 100 ns clock
`define CSSU_RC_STEP_BASE   16'hcccd
`define CSSU_TRIM_MID_STEP  16'h0800
`define CSSU_LF_STEP        16'h0347
`define CSSU_TRIM_DEFAULT   8'h80

// start-up timing
`define CSSU_CLK_PERIOD_NS  100
`define CSSU_DELAY_SHORT_US 4000
`define CSSU_DELAY_LONG_US  65000
`define CSSU_RESET_CK       8'd14
`define CSSU_WAKE_CK        8'd6

`endif

// [verilog/cssu_pkg.sv]
// cssu_pkg: types of the clock source select and start-up block.
// assumes cssu_map.svh on the include path.
package cssu_pkg;
  `include "cssu_map.svh"

  // fuse bits as sampled from non-volatile configuration
  typedef struct packed {
    logic       clockOut;
    logic       divByEight;
    logic [1:0] startupTime;
    logic [3:0] sourceSelect;
  } cssu_fuse_type;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_DELAY = 3'b001,
    ST_CK14  = 3'b010,
    ST_RUN   = 3'b011,
    ST_SLEEP = 3'b100,
    ST_WAKE  = 3'b101
  } cssu_state_type;
endpackage

// [verilog/cssu_prescaler.sv]
// cssu_prescaler: divides a stream of source ticks by a power of two.
// assumes srcTick is a one-cycle pulse on clk; divTick marks every n-th one.
`timescale 1ns/1ns
`include "cssu_map.svh"
module cssu_prescaler
  import cssu_pkg::*;
#(
  parameter int COUNT_WIDTH = 8
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       srcTick,
  input  wire logic [3:0] divSel,
  output logic            divTick
);
  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] mask;

  // codes above the largest legal one divide by the largest factor
  function automatic logic [COUNT_WIDTH-1:0] divMask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `CSSU_PRESC_MAX) ? `CSSU_PRESC_MAX : sel;
    return COUNT_WIDTH'((9'h001 << s) - 9'h001);
  endfunction

  assign mask    = divMask(divSel);
  assign divTick = srcTick && ((count & mask) == mask);

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else if (ce && srcTick) begin
      count <= count + COUNT_WIDTH'(1);
    end
  end
endmodule

// [verilog/cssu_clock_ctrl.sv]
// cssu_clock_ctrl: clock source selection, oscillator trim, start-up delays,
// timer oscillator gating and clock output of a small microcontroller.
// assumes fuse and calibration inputs are static words on clk; pins are
// asynchronous and pass a two-flop synchroniser. chipReset is the device reset
// level from the same clock; srst only initialises this logic.
//
// How it works
// - rc oscillator runs 8.0MHz at mid trim
// - source code 0010 selects calibrated rc
// - every reset loads factory trim value
// - software trim writes retune the rc
// - reset time-out uses independent timebase
// - wake from power-down waits 6 CK
// - sut picks 14CK, +4ms or +65ms
// - shipped fuses: div8, rc 0010, sut 10
// - source code 0011 selects 128kHz oscillator
// - source code 0000 selects external clock pin
// - timer oscillator only with rc system clock
// - external_clock_pin bit takes external timer pin clock
// - clock-out fuse drives system clock on pin
// - clock output keeps running during reset
// - clock output shows the divided clock
// - clock output works with every source
// - div8 fuse divides system clock by eight
// - prescaler field resets 0011 or 0000
`timescale 1ns/1ns
`include "cssu_map.svh"
module cssu_clock_ctrl
  import cssu_pkg::*;
#(
  parameter int SHORT_DELAY_CYCLES = (`CSSU_DELAY_SHORT_US * 1000) / `CSSU_CLK_PERIOD_NS,
  parameter int LONG_DELAY_CYCLES  = (`CSSU_DELAY_LONG_US * 1000) / `CSSU_CLK_PERIOD_NS,
  parameter int DELAY_WIDTH        = 20
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire cssu_fuse_type fuseIn,
  input  wire logic [7:0]    factoryTrim,
  input  wire logic          chipReset,
  input  wire logic          sleepEnter,
  input  wire logic          wakeEvent,
  input  wire logic          externalClockPin,
  input  wire logic          timerOscInputPin,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               sysClkTick,
  output logic               coreResetOut,
  output logic [7:0]         oscillatorTrim,
  output logic               clockOutputPin,
  output logic               clockOutputEn,
  output logic               timerClockTick,
  output logic               timerOscOutputPin,
  output logic               timerOscOutputEn
);
  localparam logic [DELAY_WIDTH-1:0] SHORT_LOAD = DELAY_WIDTH'(SHORT_DELAY_CYCLES - 1);
  localparam logic [DELAY_WIDTH-1:0] LONG_LOAD  = DELAY_WIDTH'(LONG_DELAY_CYCLES - 1);

  cssu_fuse_type  fuse;
  cssu_state_type state;
  cssu_state_type next_state;
  logic [3:0]     prescalerSelect;
  logic           timerOscRequest;
  logic           timerExtClockEnable;
  logic [15:0]    rcPhase;
  logic [15:0]    lfPhase;
  logic [15:0]    rcStep;
  logic [16:0]    rcSum;
  logic [16:0]    lfSum;
  logic [1:0]     extSync;
  logic [1:0]     tmrSync;
  logic           extLast;
  logic           tmrLast;
  logic           srcTick;
  logic           divTick;
  logic           srcValid;
  logic           timerAllowed;
  logic           inReset;
  logic [DELAY_WIDTH-1:0] delayCount;
  logic [7:0]     ckCount;
  logic           mapped;
  logic           wrEn;
  logic [31:0]    readWord;
  logic [11:0]    statusWord;

  // one adder shape for both oscillator models; carry out is the tick
  function automatic logic [16:0] phaseStep(input logic [15:0] phase,
                                            input logic [15:0] step);
    return {1'b0, phase} + {1'b0, step};
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    return addr == `CSSU_OFS_TRIM || addr == `CSSU_OFS_PRESCALE ||
           addr == `CSSU_OFS_TIMER_CTRL || addr == `CSSU_OFS_STATUS;
  endfunction

  assign inReset = srst || chipReset;

  // fuses are taken while reset is asserted and then held static
  always_ff @(posedge clk) begin
    if (inReset) begin
      fuse <= fuseIn;
    end
  end

  // pin synchronisers; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (srst) begin
      extSync <= 2'b00;
      tmrSync <= 2'b00;
      extLast <= 1'b0;
      tmrLast <= 1'b0;
    end else if (ce) begin
      extSync <= {extSync[0], externalClockPin};
      tmrSync <= {tmrSync[0], timerOscInputPin};
      extLast <= extSync[1];
      tmrLast <= tmrSync[1];
    end
  end

  // rc step moves 16 per trim code around the mid point; mid trim gives 8.0MHz
  assign rcStep = `CSSU_RC_STEP_BASE + {4'h0, oscillatorTrim, 4'h0}
                  - `CSSU_TRIM_MID_STEP;
  assign rcSum  = phaseStep(rcPhase, rcStep);
  assign lfSum  = phaseStep(lfPhase, `CSSU_LF_STEP);

  // oscillators keep running through chip reset so the clock output can too
  always_ff @(posedge clk) begin
    if (srst) begin
      rcPhase <= '0;
      lfPhase <= '0;
    end else if (ce) begin
      rcPhase <= rcSum[15:0];
      lfPhase <= lfSum[15:0];
    end
  end

  // exactly one source feeds the system path; unknown codes feed none
  always_comb begin
    srcTick  = 1'b0;
    srcValid = 1'b1;
    case (fuse.sourceSelect)
      `CSSU_SRC_RC:       srcTick = rcSum[16];
      `CSSU_SRC_LOWFREQ:  srcTick = lfSum[16];
      `CSSU_SRC_EXTERNAL: srcTick = extSync[1] && !extLast;
      default:            srcValid = 1'b0;
    endcase
  end

  cssu_prescaler #(
    .COUNT_WIDTH (8)
  ) u_prescaler (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .srcTick (srcTick),
    .divSel  (prescalerSelect),
    .divTick (divTick)
  );

  // start-up sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (fuse.startupTime == `CSSU_SUT_SHORT || fuse.startupTime == `CSSU_SUT_LONG) begin
          next_state = ST_DELAY;
        end else begin
          next_state = ST_CK14;
        end
      end
      ST_DELAY: begin
        if (delayCount == '0) begin
          next_state = ST_CK14;
        end
      end
      ST_CK14: begin
        if (srcTick && ckCount == 8'd1) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleepEnter) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (srcTick && ckCount == 8'd1) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (inReset) begin
      state <= ST_HOLD;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // millisecond delay counts the fixed clock, never the trimmed rc
  always_ff @(posedge clk) begin
    if (inReset) begin
      delayCount <= '0;
    end else if (ce) begin
      if (state == ST_HOLD) begin
        delayCount <= (fuse.startupTime == `CSSU_SUT_LONG) ? LONG_LOAD : SHORT_LOAD;
      end else if (state == ST_DELAY && delayCount != '0) begin
        delayCount <= delayCount - DELAY_WIDTH'(1);
      end
    end
  end

  // source cycle counts: 14 after reset, 6 after wake whatever the sut code
  always_ff @(posedge clk) begin
    if (inReset) begin
      ckCount <= `CSSU_RESET_CK;
    end else if (ce) begin
      if (state == ST_HOLD || state == ST_DELAY) begin
        ckCount <= `CSSU_RESET_CK;
      end else if (state == ST_SLEEP) begin
        ckCount <= `CSSU_WAKE_CK;
      end else if ((state == ST_CK14 || state == ST_WAKE) && srcTick) begin
        ckCount <= ckCount - 8'd1;
      end
    end
  end

  // the core stays in reset and unclocked until the sequencer reaches run
  always_ff @(posedge clk) begin
    if (srst) begin
      coreResetOut <= 1'b1;
      sysClkTick   <= 1'b0;
    end else if (ce) begin
      coreResetOut <= chipReset || (state != ST_RUN && state != ST_SLEEP &&
                                    state != ST_WAKE);
      sysClkTick   <= divTick && state == ST_RUN && !chipReset;
    end
  end

  // clock output: half a divided period per divided tick, also during chip reset
  always_ff @(posedge clk) begin
    if (srst) begin
      clockOutputPin <= 1'b0;
      clockOutputEn  <= 1'b0;
    end else if (ce) begin
      clockOutputEn <= fuse.clockOut;
      if (fuse.clockOut && divTick) begin
        clockOutputPin <= !clockOutputPin;
      end else if (!fuse.clockOut) begin
        clockOutputPin <= 1'b0;
      end
    end
  end

  // timer oscillator shares the crystal pins: usable only on the rc source
  assign timerAllowed = timerOscRequest && fuse.sourceSelect == `CSSU_SRC_RC;

  always_ff @(posedge clk) begin
    if (srst) begin
      timerClockTick    <= 1'b0;
      timerOscOutputPin <= 1'b0;
      timerOscOutputEn  <= 1'b0;
    end else if (ce) begin
      timerClockTick    <= timerAllowed && tmrSync[1] && !tmrLast;
      // crystal mode drives the inverting amplifier pin; external mode releases it
      timerOscOutputPin <= !tmrSync[1];
      timerOscOutputEn  <= timerAllowed && !timerExtClockEnable;
    end
  end

  // apb slave: zero wait states, registered read data
  assign mapped  = isMapped(paddr);
  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;
  assign wrEn    = ce && psel && penable && pwrite && mapped;

  // trim reloads on every reset, software may retune afterwards
  always_ff @(posedge clk) begin
    if (inReset) begin
      oscillatorTrim <= factoryTrim;
    end else if (wrEn && paddr == `CSSU_OFS_TRIM) begin
      oscillatorTrim <= pwdata[7:0];
    end
  end

  // prescaler reset value follows the divide-by-eight fuse; any code writable
  always_ff @(posedge clk) begin
    if (inReset) begin
      prescalerSelect <= fuseIn.divByEight ? `CSSU_PRESC_DIV8 : `CSSU_PRESC_DIV1;
    end else if (wrEn && paddr == `CSSU_OFS_PRESCALE) begin
      prescalerSelect <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (inReset) begin
      timerOscRequest     <= 1'b0;
      timerExtClockEnable <= 1'b0;
    end else if (wrEn && paddr == `CSSU_OFS_TIMER_CTRL) begin
      timerOscRequest     <= pwdata[`CSSU_TCTRL_OSC_EN_BIT];
      timerExtClockEnable <= pwdata[`CSSU_TCTRL_EXTERNAL_CLOCK_PIN_BIT];
    end
  end

  // reserved sut is only flagged; the block then behaves as for code 00
  always_comb begin
    statusWord = '0;
    statusWord[`CSSU_STAT_SRC_LSB +: 4] = fuse.sourceSelect;
    statusWord[`CSSU_STAT_SUT_LSB +: 2] = fuse.startupTime;
    statusWord[`CSSU_STAT_DIV8_BIT]     = fuse.divByEight;
    statusWord[`CSSU_STAT_CLKOUT_BIT]   = fuse.clockOut;
    statusWord[`CSSU_STAT_RUNNING_BIT]  = state == ST_RUN;
    statusWord[`CSSU_STAT_TIMER_BIT]    = timerAllowed;
    statusWord[`CSSU_STAT_SUT_BAD_BIT]  = fuse.startupTime == `CSSU_SUT_RESERVED;
    statusWord[`CSSU_STAT_SRC_BAD_BIT]  = !srcValid;
  end

  always_comb begin
    readWord = '0;
    case (paddr)
      `CSSU_OFS_TRIM:       readWord = {24'h000000, oscillatorTrim};
      `CSSU_OFS_PRESCALE:   readWord = {28'h0000000, prescalerSelect};
      `CSSU_OFS_TIMER_CTRL: readWord = {30'h00000000, timerExtClockEnable, timerOscRequest};
      `CSSU_OFS_STATUS:     readWord = {20'h00000, statusWord};
      default:              readWord = '0;
    endcase
  end

  // captured in the setup cycle so the access cycle sees a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= '0;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= readWord;
    end
  end
endmodule

// [tb/cssu_clock_source.sv]
// cssu_clock_source: external clock source and watch crystal at the pins.
// assumes the bench clock; pins move only just after rising edges.
`timescale 1ns/1ns
module cssu_clock_source (
  input  wire logic clk,
  output logic      extPin,
  output logic      timerPin
);
  logic [3:0] phase = 4'h0;
  // fixed rate, so no step between cycles
  always_ff @(posedge clk) begin
    phase <= phase + 4'h1;
  end
  assign extPin   = phase[1];
  // crystal at a quarter of the source rate
  assign timerPin = phase[3];
endmodule

// [tb/cssu_clock_ctrl_asserts.sv]
// cssu_clock_ctrl_asserts: port checks of the clock control block.
// assumes one clk domain with srst as its reset.
`timescale 1ns/1ns
`include "cssu_map.svh"
module cssu_clock_ctrl_asserts
  import cssu_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        chipReset,
  input wire logic [7:0]  factoryTrim,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sysClkTick,
  input wire logic        coreResetOut,
  input wire logic [7:0]  oscillatorTrim,
  input wire logic        clockOutputPin,
  input wire logic        clockOutputEn,
  input wire logic        timerClockTick,
  input wire logic        timerOscOutputPin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
  sequence s_access;
    psel && penable && ce;
  endsequence
  sequence s_trim_write;
    s_access ##0 (pwrite && paddr == `CSSU_OFS_TRIM && !chipReset);
  endsequence
  sequence s_release;
    chipReset ##1 !chipReset;
  endsequence
  pready_ce_a: assert property (pready == ce)
    else $error("pready differs from ce");
  slverr_map_a: assert property (s_access |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  unmapped_zero_a: assert property (s_access ##0 (!pwrite && !mapped) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  trim_load_a: assert property (chipReset && ce |=> oscillatorTrim == $past(factoryTrim))
    else $error("trim not loaded in reset");
  trim_write_a: assert property (s_trim_write |=> oscillatorTrim == $past(pwdata[7:0]))
    else $error("trim write lost");
  reset_hold_a: assert property (s_release |-> coreResetOut [*8])
    else $error("core released too early");
  tick_gate_a: assert property (coreResetOut [*3] |-> !sysClkTick)
    else $error("system tick while held");
  clkout_idle_a: assert property (!clockOutputEn [*2] |-> !clockOutputPin)
    else $error("clock pin moves without fuse");
  xtal_phase_a: assert property (timerClockTick |-> !timerOscOutputPin)
    else $error("timer drive pin not inverted");
endmodule
bind cssu_clock_ctrl cssu_clock_ctrl_asserts u_asserts (
  .clk(clk), .srst(srst), .ce(ce), .chipReset(chipReset), .factoryTrim(factoryTrim),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysClkTick(sysClkTick),
  .coreResetOut(coreResetOut), .oscillatorTrim(oscillatorTrim),
  .clockOutputPin(clockOutputPin), .clockOutputEn(clockOutputEn),
  .timerClockTick(timerClockTick), .timerOscOutputPin(timerOscOutputPin)
);

// [tb/test_clock_source_select_startup.sv]
// test_clock_source_select_startup: scenario bench of cssu_clock_ctrl.
// assumes cssu_clock_source on both oscillator pins; fuses change in reset, except in the source-held check of t_sources.
`timescale 1ns/1ns
`include "cssu_map.svh"
module test_clock_source_select_startup;
  import cssu_pkg::*;
  localparam int SHORT = 20;
  localparam int LONG  = 40;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, chipReset = 1'b0;
  logic sleepEnter = 1'b0, wakeEvent = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  cssu_fuse_type fz = `CSSU_FUSE_SHIPPED;
  logic [7:0] factory = 8'h80;
  logic pready, pslverr, sysClkTick, coreResetOut, clockOutputPin, clockOutputEn;
  logic timerClockTick, timerOscOutputPin, timerOscOutputEn, extPin, timerPin, lastErr;
  logic [7:0] oscillatorTrim;
  int miscompares = 0, n_checks = 0;
  cssu_clock_source u_src (.clk(clk), .extPin(extPin), .timerPin(timerPin));
  cssu_clock_ctrl #(.SHORT_DELAY_CYCLES(SHORT), .LONG_DELAY_CYCLES(LONG)) dut (
    .clk(clk), .srst(srst), .ce(ce), .fuseIn(fz), .factoryTrim(factory),
    .chipReset(chipReset), .sleepEnter(sleepEnter), .wakeEvent(wakeEvent),
    .externalClockPin(extPin), .timerOscInputPin(timerPin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysClkTick(sysClkTick),
    .coreResetOut(coreResetOut), .oscillatorTrim(oscillatorTrim),
    .clockOutputPin(clockOutputPin), .clockOutputEn(clockOutputEn),
    .timerClockTick(timerClockTick), .timerOscOutputPin(timerOscOutputPin),
    .timerOscOutputEn(timerOscOutputEn));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkr(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // counts system ticks, clock pin changes and timer ticks
  task automatic count(input int n, output int t, output int g, output int m);
    logic pin;
    t = 0;
    g = 0;
    m = 0;
    pin = clockOutputPin;
    repeat (n) begin
      @(posedge clk);
      t += (sysClkTick === 1'b1);
      m += (timerClockTick === 1'b1);
      g += (clockOutputPin !== pin);
      pin = clockOutputPin;
    end
  endtask
  // 64 cycles of chip reset, then cycles until the core is let go
  task automatic restart(input cssu_fuse_type f, output int held, output int g);
    int t, m;
    @(posedge clk);
    fz <= f;
    chipReset <= 1'b1;
    count(64, t, g, m);
    chipReset <= 1'b0;
    held = 0;
    do begin
      @(posedge clk);
      held++;
    end while (coreResetOut !== 1'b0 && held < 2000);
  endtask
  task automatic t_reset_values();
    apb(1'b0, `CSSU_OFS_TRIM, 32'h0);
    chk("trim", 32'h80, rd);
    apb(1'b0, `CSSU_OFS_PRESCALE, 32'h0);
    chk("prescale", 32'h3, rd);
    apb(1'b1, `CSSU_OFS_STATUS, 32'hff);
    apb(1'b0, `CSSU_OFS_STATUS, 32'h0);
    chk("status fuses", {24'h0, `CSSU_FUSE_SHIPPED}, {24'h0, rd[7:0]});
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, lastErr});
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_rc();
    int h, g, t, m;
    apb(1'b1, `CSSU_OFS_TRIM, 32'h33);
    // a factory value off mid trim proves the reload takes the input
    factory <= 8'h5a;
    restart({1'b1, 1'b0, 2'h0, `CSSU_SRC_RC}, h, g);
    chk("trim reload", 32'h5a, {24'h0, oscillatorTrim});
    factory <= 8'h80;
    apb(1'b1, `CSSU_OFS_TRIM, 32'h80);
    count(160, t, g, m);
    chkr("rc ticks", 126, 130, t);
    chkr("rc clock out", 126, 130, g);
    apb(1'b1, `CSSU_OFS_TRIM, 32'hff);
    repeat (2) @(posedge clk);
    chk("trim port", 32'hff, {24'h0, oscillatorTrim});
    count(160, t, g, m);
    chkr("trimmed ticks", 131, 135, t);
  endtask
  task automatic t_startup();
    int h, g;
    int dly[3] = '{0, SHORT, LONG};
    // code 11 is reserved and never configured
    for (int s = 0; s < 3; s++) begin
      restart({1'b0, s[0], s[1:0], `CSSU_SRC_EXTERNAL}, h, g);
      chkr("startup hold", dly[s] + 50, dly[s] + 66, h);
      apb(1'b0, `CSSU_OFS_PRESCALE, 32'h0);
      chk("prescale reset", s[0] ? 32'h3 : 32'h0, rd);
    end
  endtask
  task automatic t_divide();
    int h, g, t, m;
    restart({1'b1, 1'b1, 2'h0, `CSSU_SRC_EXTERNAL}, h, g);
    chkr("clock out in reset", 1, 3, g);
    chk("clock out enable", 32'h1, {31'h0, clockOutputEn});
    count(160, t, g, m);
    chkr("div8 ticks", 4, 6, t);
    for (int c = 0; c < 3; c += 2) begin
      apb(1'b1, `CSSU_OFS_PRESCALE, c);
      repeat (20) @(posedge clk);
      count(160, t, g, m);
      chkr("ext ticks", (40 >> c) - 1, (40 >> c) + 1, t);
      chkr("divided clock out", (40 >> c) - 1, (40 >> c) + 1, g);
    end
  endtask
  task automatic t_sleep();
    int t, g, m, n;
    // undivided ticks make the first tick after wake land at a known cycle
    apb(1'b1, `CSSU_OFS_PRESCALE, 32'h0);
    @(posedge clk);
    sleepEnter <= 1'b1;
    @(posedge clk);
    sleepEnter <= 1'b0;
    repeat (2) @(posedge clk);
    count(40, t, g, m);
    chk("ticks asleep", 32'h0, t);
    @(posedge clk);
    wakeEvent <= 1'b1;
    @(posedge clk);
    wakeEvent <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sysClkTick !== 1'b1 && n < 200);
    chkr("wake cycles", 26, 29, n);
  endtask
  task automatic t_timer();
    int h, g, t, m;
    restart({1'b0, 1'b0, 2'h0, `CSSU_SRC_RC}, h, g);
    apb(1'b1, `CSSU_OFS_TIMER_CTRL, 32'h1);
    count(160, t, g, m);
    chkr("timer ticks", 9, 11, m);
    chk("crystal drive", 32'h1, {31'h0, timerOscOutputEn});
    apb(1'b1, `CSSU_OFS_TIMER_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk("ext timer drive", 32'h0, {31'h0, timerOscOutputEn});
    count(160, t, g, m);
    chkr("ext timer ticks", 9, 11, m);
    restart({1'b0, 1'b0, 2'h0, `CSSU_SRC_EXTERNAL}, h, g);
    apb(1'b1, `CSSU_OFS_TIMER_CTRL, 32'h1);
    count(160, t, g, m);
    chk("timer blocked", 32'h0, m);
  endtask
  task automatic t_sources();
    int h, g, t, m;
    restart({1'b0, 1'b0, 2'h0, `CSSU_SRC_LOWFREQ}, h, g);
    count(1600, t, g, m);
    chkr("lf ticks", 19, 22, t);
    @(posedge clk);
    fz <= {1'b0, 1'b0, 2'h0, `CSSU_SRC_EXTERNAL};
    apb(1'b0, `CSSU_OFS_STATUS, 32'h0);
    chk("source held", 32'h3, {28'h0, rd[3:0]});
    restart({1'b0, 1'b0, 2'h0, 4'h5}, h, g);
    count(160, t, g, m);
    chk("no source ticks", 32'h0, t);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset_values();
    t_rc();
    t_startup();
    t_divide();
    t_sleep();
    t_timer();
    t_sources();
    final_report();
  end
  initial begin
    #4000000;
    miscompares++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end
endmodule
